// ### rtl/rba_pkg.sv
package rba_pkg;
  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] CTRL_OFF     = 8'h00;  // Read/write control word
  localparam logic [7:0] STATUS_OFF   = 8'h04;  // Live hardware status, read only
  localparam logic [7:0] EVTCNT_OFF   = 8'h08;  // Event counter, read to clear
  localparam logic [7:0] KEY_OFF      = 8'h0c;  // Write-only key word
  localparam logic [7:0] W1C_OFF      = 8'h10;  // Sticky flags, write one to clear
  localparam logic [7:0] ZCLR_OFF     = 8'h14;  // Sticky flags, write zero to clear
  localparam logic [7:0] LATCH_OFF    = 8'h18;  // Latch-low and latch-high status
  localparam logic [7:0] CMD_OFF      = 8'h1c;  // Self-clearing command bits
  localparam logic [7:0] IRQ_STAT_OFF = 8'h20;  // Interrupt status, read only
  localparam logic [7:0] IRQ_EN_OFF   = 8'h24;  // Interrupt enable
  localparam logic [7:0] IRQ_CLR_OFF  = 8'h28;  // Interrupt clear, write only
  localparam logic [7:0] PHY_CMD_OFF  = 8'h2c;  // PHY management command
  localparam logic [7:0] PHY_DATA_OFF = 8'h30;  // PHY read data and busy flag

  // Word-address mask drops the byte lane bits
  localparam logic [7:0] WORD_MASK    = 8'hfc;

  // Latch register layout: low byte latch-low, next byte latch-high
  localparam int LATCH_W     = 8;
  localparam int LATCH_HI_LSB = 8;

  // Interrupt status bits
  localparam int IRQ_W        = 4;
  localparam int IRQ_LOW_BIT  = 0;
  localparam int IRQ_HIGH_BIT = 1;
  localparam int IRQ_EVT_BIT  = 2;
  localparam int IRQ_PHY_BIT  = 3;

  // PHY command layout
  localparam int PHY_DATA_LSB = 0;
  localparam int PHY_DATA_W   = 16;
  localparam int PHY_REG_LSB  = 16;
  localparam int PHY_ADDR_LSB = 21;
  localparam int PHY_FIELD_W  = 5;
  localparam int PHY_RD_BIT   = 26;
  localparam int PHY_BUSY_BIT = 31;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  typedef enum logic {PHY_IDLE, PHY_BUSY} rba_phy_state_type;
endpackage : rba_pkg

// ### rtl/rba_register_bank.sv
`timescale 1ns/1ps
// Functional notes
// R1: Readable fields return current contents; writable fields store host write data.
// R2: Read-only fields return their value and ignore every host write.
// R3: Read-to-clear field zeroes after a completed read; writes do nothing. The code clears when the read address is accepted, before the data handshake.
// R4: Write-only field takes write data; reads return undefined value.
// R5: Write-one-to-clear: bits written one clear, bits written zero stay.
// R6: Write-zero-to-clear: bits written zero clear, bits written one stay.
// R7: Latch-low bit holds low until read, then follows live condition.
// R8: Latch-high bit holds high until read, then follows live condition.
// R9: Self-clearing field returns to zero itself; zero writes do nothing.
// R10: Host writes zeros to reserved fields and ignores their read value.
// R11: Whole register space is reachable through the host management port.
// R12: PHY registers are reached through a serial management command path.
// R13: Clearing read returns pre-clear value; clear visible the next cycle.
// R14: Hardware set beats host clear in the same cycle.
module rba_register_bank #(
  parameter int DATA_W = 32,
  parameter int CNT_W  = 32
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [DATA_W/8-1:0]   s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_W-1:0]          s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [DATA_W-1:0]     hwStatus,
  input  wire logic                  countEvent,
  input  wire logic [DATA_W-1:0]     w1cSet,
  input  wire logic [DATA_W-1:0]     zeroClrSet,
  input  wire logic [rba_pkg::LATCH_W-1:0] condLow,
  input  wire logic [rba_pkg::LATCH_W-1:0] condHigh,
  output logic [DATA_W-1:0]          ctrlOut,
  output logic [DATA_W-1:0]          keyOut,
  output logic [DATA_W-1:0]          cmdPulse,
  output logic                       irq,
  output logic                       miimStart,
  output logic                       miimRead,
  output logic [rba_pkg::PHY_FIELD_W-1:0] miimPhyAddr,
  output logic [rba_pkg::PHY_FIELD_W-1:0] miimRegAddr,
  output logic [rba_pkg::PHY_DATA_W-1:0]  miimWrData,
  input  wire logic                  miimDone,
  input  wire logic [rba_pkg::PHY_DATA_W-1:0] miimRdData
);
  // Word address match, shared by read and write decode
  function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] off);
    hitReg = (addr & rba_pkg::WORD_MASK) == off;
  endfunction : hitReg
  // Expand byte strobes into a bit mask
  function automatic logic [DATA_W-1:0] strbMask(input logic [DATA_W/8-1:0] strb);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < DATA_W/8; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    strbMask = m;
  endfunction : strbMask
  logic                   awReadyFf, wReadyFf, bValidFf, arReadyFf, rValidFf;
  logic                   nxt_awReady, nxt_wReady, nxt_bValid, nxt_arReady, nxt_rValid;
  logic                   awHaveFf, wHaveFf, nxt_awHave, nxt_wHave;
  logic [7:0]             awAddrFf, nxt_awAddr;
  logic [DATA_W-1:0]      wDataFf, nxt_wData;
  logic [DATA_W/8-1:0]    wStrbFf, nxt_wStrb;
  logic [1:0]             bRespFf, nxt_bResp, rRespFf, nxt_rResp;
  logic [DATA_W-1:0]      rDataFf, nxt_rData;
  logic [DATA_W-1:0]      ctrlFf, nxt_ctrl, keyFf, nxt_key, pulseFf, nxt_pulse;
  logic [DATA_W-1:0]      w1cFf, nxt_w1c, zeroClrFf, nxt_zeroClr;
  logic [CNT_W-1:0]       cntFf, nxt_cnt;
  logic [rba_pkg::LATCH_W-1:0] lowLatchFf, nxt_lowLatch, highLatchFf, nxt_highLatch;
  logic [rba_pkg::IRQ_W-1:0]   irqStatFf, nxt_irqStat, irqEnFf, nxt_irqEn;
  logic                   irqFf, nxt_irq;
  rba_pkg::rba_phy_state_type phyStateFf, nxt_phyState;
  logic                   miimStartFf, nxt_miimStart, miimReadFf, nxt_miimRead;
  logic [rba_pkg::PHY_FIELD_W-1:0] miimPhyFf, nxt_miimPhy, miimRegFf, nxt_miimReg;
  logic [rba_pkg::PHY_DATA_W-1:0]  miimWrFf, nxt_miimWr, phyRdFf, nxt_phyRd;
  logic              doWrite, rdHit;
  logic [DATA_W-1:0] wMask, wBits;
  logic [rba_pkg::LATCH_W-1:0] lowVal, highVal;
  logic [rba_pkg::IRQ_W-1:0]   irqEvt, irqClr;
  assign doWrite = awHaveFf && wHaveFf && !bValidFf;
  assign rdHit   = s_axi_arvalid && arReadyFf;
  assign wMask   = strbMask(wStrbFf);
  assign wBits   = wDataFf & wMask;
  // Latched views: a latched bit overrides the live condition
  assign lowVal  = condLow & ~lowLatchFf;  // R7
  assign highVal = condHigh | highLatchFf;  // R8
  // Bus channel handshakes; address and data are taken in either order
  always_comb begin
    nxt_awHave = awHaveFf;
    nxt_awAddr = awAddrFf;
    nxt_wHave  = wHaveFf;
    nxt_wData  = wDataFf;
    nxt_wStrb  = wStrbFf;
    nxt_bValid = bValidFf;
    nxt_bResp  = bRespFf;
    if (s_axi_awvalid && awReadyFf) begin
      nxt_awHave = 1'b1;
      nxt_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReadyFf) begin
      nxt_wHave = 1'b1;
      nxt_wData = s_axi_wdata;
      nxt_wStrb = s_axi_wstrb;
    end
    if (bValidFf && s_axi_bready) begin
      nxt_bValid = 1'b0;
    end
    if (doWrite) begin
      nxt_awHave = 1'b0;
      nxt_wHave  = 1'b0;
      nxt_bValid = 1'b1;
      // Unmapped or read-only targets answer with an error, contents untouched
      nxt_bResp  = (hitReg(awAddrFf, rba_pkg::CTRL_OFF) || hitReg(awAddrFf, rba_pkg::KEY_OFF)
                    || hitReg(awAddrFf, rba_pkg::W1C_OFF) || hitReg(awAddrFf, rba_pkg::ZCLR_OFF)
                    || hitReg(awAddrFf, rba_pkg::CMD_OFF) || hitReg(awAddrFf, rba_pkg::IRQ_EN_OFF)
                    || hitReg(awAddrFf, rba_pkg::IRQ_CLR_OFF)
                    || hitReg(awAddrFf, rba_pkg::PHY_CMD_OFF))
                   ? rba_pkg::RESP_OKAY : rba_pkg::RESP_SLVERR;
    end
    nxt_awReady = !nxt_awHave;
    nxt_wReady  = !nxt_wHave;
  end

  // Read channel; the value is captured before any clearing side effect lands
  always_comb begin
    nxt_rValid = rValidFf;
    nxt_rData  = rDataFf;
    nxt_rResp  = rRespFf;
    if (rValidFf && s_axi_rready) begin
      nxt_rValid = 1'b0;
    end
    if (rdHit) begin  // R11
      nxt_rValid = 1'b1;
      nxt_rResp  = rba_pkg::RESP_OKAY;
      nxt_rData  = rba_pkg::ZERO_WORD;  // Reserved bits read zero
      if (hitReg(s_axi_araddr, rba_pkg::CTRL_OFF)) begin
        nxt_rData = ctrlFf;  // R1
      end else if (hitReg(s_axi_araddr, rba_pkg::STATUS_OFF)) begin
        nxt_rData = hwStatus;  // R2
      end else if (hitReg(s_axi_araddr, rba_pkg::EVTCNT_OFF)) begin
        nxt_rData = DATA_W'(cntFf);  // R13
      end else if (hitReg(s_axi_araddr, rba_pkg::KEY_OFF)) begin
        nxt_rData = rba_pkg::ZERO_WORD;  // R4
      end else if (hitReg(s_axi_araddr, rba_pkg::W1C_OFF)) begin
        nxt_rData = w1cFf;
      end else if (hitReg(s_axi_araddr, rba_pkg::ZCLR_OFF)) begin
        nxt_rData = zeroClrFf;
      end else if (hitReg(s_axi_araddr, rba_pkg::LATCH_OFF)) begin
        nxt_rData[rba_pkg::LATCH_W-1:0] = lowVal;
        nxt_rData[rba_pkg::LATCH_HI_LSB +: rba_pkg::LATCH_W] = highVal;
      end else if (hitReg(s_axi_araddr, rba_pkg::CMD_OFF)) begin
        nxt_rData = pulseFf;  // R9
      end else if (hitReg(s_axi_araddr, rba_pkg::IRQ_STAT_OFF)) begin
        nxt_rData[rba_pkg::IRQ_W-1:0] = irqStatFf;
      end else if (hitReg(s_axi_araddr, rba_pkg::IRQ_EN_OFF)) begin
        nxt_rData[rba_pkg::IRQ_W-1:0] = irqEnFf;
      end else if (hitReg(s_axi_araddr, rba_pkg::PHY_DATA_OFF)) begin
        nxt_rData[rba_pkg::PHY_DATA_W-1:0] = phyRdFf;
        nxt_rData[rba_pkg::PHY_BUSY_BIT]   = (phyStateFf == rba_pkg::PHY_BUSY);
      end else if (!hitReg(s_axi_araddr, rba_pkg::IRQ_CLR_OFF)
                   && !hitReg(s_axi_araddr, rba_pkg::PHY_CMD_OFF)) begin
        nxt_rResp = rba_pkg::RESP_SLVERR;
      end
    end
    nxt_arReady = !nxt_rValid;
  end

  // Field storage; hardware sets are ORed in after the host clear
  always_comb begin
    logic wrCtrl, wrKey, wrW1c, wrZero, wrPulse;
    wrCtrl  = doWrite && hitReg(awAddrFf, rba_pkg::CTRL_OFF);
    wrKey   = doWrite && hitReg(awAddrFf, rba_pkg::KEY_OFF);
    wrW1c   = doWrite && hitReg(awAddrFf, rba_pkg::W1C_OFF);
    wrZero  = doWrite && hitReg(awAddrFf, rba_pkg::ZCLR_OFF);
    wrPulse = doWrite && hitReg(awAddrFf, rba_pkg::CMD_OFF);
    nxt_ctrl = wrCtrl ? ((ctrlFf & ~wMask) | wBits) : ctrlFf;  // R1
    nxt_key  = wrKey ? ((keyFf & ~wMask) | wBits) : keyFf;  // R4
    nxt_w1c  = (wrW1c ? (w1cFf & ~wBits) : w1cFf) | w1cSet;  // R5 R14
    // Unstrobed lanes count as ones so they never clear
    nxt_zeroClr = (wrZero ? (zeroClrFf & (wDataFf | ~wMask)) : zeroClrFf) | zeroClrSet;  // R6 R14
    // Held one cycle, so the command is a single pulse
    nxt_pulse = wrPulse ? wBits : rba_pkg::ZERO_WORD;  // R9
    // Read clear and count collide: the new event survives
    if (rdHit && hitReg(s_axi_araddr, rba_pkg::EVTCNT_OFF)) begin
      nxt_cnt = CNT_W'(countEvent);  // R3 R13 R14
    end else begin
      nxt_cnt = cntFf + CNT_W'(countEvent);
    end
    // Reading the latch register releases both latches
    if (rdHit && hitReg(s_axi_araddr, rba_pkg::LATCH_OFF)) begin
      nxt_lowLatch  = ~condLow;  // R7 R14
      nxt_highLatch = condHigh;  // R8 R14
    end else begin
      nxt_lowLatch  = lowLatchFf | ~condLow;  // R7
      nxt_highLatch = highLatchFf | condHigh;  // R8
    end
  end

  // Interrupt status, enable and clear; a set in the clear cycle is kept
  always_comb begin
    irqEvt = '0;
    irqEvt[rba_pkg::IRQ_LOW_BIT]  = |(~condLow & ~lowLatchFf);
    irqEvt[rba_pkg::IRQ_HIGH_BIT] = |(condHigh & ~highLatchFf);
    irqEvt[rba_pkg::IRQ_EVT_BIT]  = countEvent;
    irqEvt[rba_pkg::IRQ_PHY_BIT]  = miimDone && (phyStateFf == rba_pkg::PHY_BUSY);
    irqClr = (doWrite && hitReg(awAddrFf, rba_pkg::IRQ_CLR_OFF))
             ? wBits[rba_pkg::IRQ_W-1:0] : '0;
    nxt_irqStat = (irqStatFf & ~irqClr) | irqEvt;  // R14
    nxt_irqEn   = (doWrite && hitReg(awAddrFf, rba_pkg::IRQ_EN_OFF))
                  ? wBits[rba_pkg::IRQ_W-1:0] : irqEnFf;
    nxt_irq     = |(nxt_irqStat & nxt_irqEn);
  end

  // PHY management command: one request in flight, later commands dropped while busy
  always_comb begin
    nxt_phyState  = phyStateFf;
    nxt_miimStart = 1'b0;
    nxt_miimRead  = miimReadFf;
    nxt_miimPhy   = miimPhyFf;
    nxt_miimReg   = miimRegFf;
    nxt_miimWr    = miimWrFf;
    nxt_phyRd     = phyRdFf;
    unique case (phyStateFf)
      rba_pkg::PHY_IDLE: begin
        if (doWrite && hitReg(awAddrFf, rba_pkg::PHY_CMD_OFF)) begin  // R12
          nxt_phyState  = rba_pkg::PHY_BUSY;
          nxt_miimStart = 1'b1;
          nxt_miimRead  = wDataFf[rba_pkg::PHY_RD_BIT];
          nxt_miimPhy   = wDataFf[rba_pkg::PHY_ADDR_LSB +: rba_pkg::PHY_FIELD_W];
          nxt_miimReg   = wDataFf[rba_pkg::PHY_REG_LSB +: rba_pkg::PHY_FIELD_W];
          nxt_miimWr    = wDataFf[rba_pkg::PHY_DATA_LSB +: rba_pkg::PHY_DATA_W];
        end
      end
      rba_pkg::PHY_BUSY: begin
        if (miimDone) begin  // R12
          nxt_phyState = rba_pkg::PHY_IDLE;
          nxt_phyRd    = miimReadFf ? miimRdData : phyRdFf;
        end
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awReadyFf <= 1'b0; wReadyFf <= 1'b0; bValidFf <= 1'b0;
      arReadyFf <= 1'b0; rValidFf <= 1'b0;
      awHaveFf <= 1'b0; wHaveFf <= 1'b0;
      awAddrFf <= '0; wDataFf <= '0; wStrbFf <= '0;
      bRespFf <= rba_pkg::RESP_OKAY; rRespFf <= rba_pkg::RESP_OKAY; rDataFf <= '0;
      ctrlFf <= '0; keyFf <= '0; pulseFf <= '0; w1cFf <= '0; zeroClrFf <= '0; cntFf <= '0;
      lowLatchFf <= '0; highLatchFf <= '0;
      irqStatFf <= '0; irqEnFf <= '0; irqFf <= 1'b0;
      phyStateFf <= rba_pkg::PHY_IDLE; miimStartFf <= 1'b0; miimReadFf <= 1'b0;
      miimPhyFf <= '0; miimRegFf <= '0; miimWrFf <= '0; phyRdFf <= '0;
    end else begin
      awReadyFf <= nxt_awReady; wReadyFf <= nxt_wReady; bValidFf <= nxt_bValid;
      arReadyFf <= nxt_arReady; rValidFf <= nxt_rValid;
      awHaveFf <= nxt_awHave; wHaveFf <= nxt_wHave;
      awAddrFf <= nxt_awAddr; wDataFf <= nxt_wData; wStrbFf <= nxt_wStrb;
      bRespFf <= nxt_bResp; rRespFf <= nxt_rResp; rDataFf <= nxt_rData;
      ctrlFf <= nxt_ctrl; keyFf <= nxt_key; pulseFf <= nxt_pulse;
      w1cFf <= nxt_w1c; zeroClrFf <= nxt_zeroClr; cntFf <= nxt_cnt;
      lowLatchFf <= nxt_lowLatch; highLatchFf <= nxt_highLatch;
      irqStatFf <= nxt_irqStat; irqEnFf <= nxt_irqEn; irqFf <= nxt_irq;
      phyStateFf <= nxt_phyState; miimStartFf <= nxt_miimStart; miimReadFf <= nxt_miimRead;
      miimPhyFf <= nxt_miimPhy; miimRegFf <= nxt_miimReg; miimWrFf <= nxt_miimWr;
      phyRdFf <= nxt_phyRd;
    end
  end

  assign s_axi_awready = awReadyFf;
  assign s_axi_wready  = wReadyFf;
  assign s_axi_bvalid  = bValidFf;
  assign s_axi_bresp   = bRespFf;
  assign s_axi_arready = arReadyFf;
  assign s_axi_rvalid  = rValidFf;
  assign s_axi_rdata   = rDataFf;
  assign s_axi_rresp   = rRespFf;
  assign ctrlOut       = ctrlFf;
  assign keyOut        = keyFf;
  assign cmdPulse      = pulseFf;
  assign irq           = irqFf;
  assign miimStart     = miimStartFf;
  assign miimRead      = miimReadFf;
  assign miimPhyAddr   = miimPhyFf;
  assign miimRegAddr   = miimRegFf;
  assign miimWrData    = miimWrFf;

  // Checks
  ctrl_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    doWrite && hitReg(awAddrFf, rba_pkg::CTRL_OFF) && (&wStrbFf) |=> ctrlFf == $past(wDataFf))
    else $error("control word not stored");
  status_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    rdHit && hitReg(s_axi_araddr, rba_pkg::STATUS_OFF) |=> rDataFf == $past(hwStatus))
    else $error("read-only value wrong");
  cnt_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
    rdHit && hitReg(s_axi_araddr, rba_pkg::EVTCNT_OFF) && !countEvent |=> cntFf == '0)
    else $error("read-to-clear did not clear");
  cnt_value_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
    rdHit && hitReg(s_axi_araddr, rba_pkg::EVTCNT_OFF) |=> rDataFf == DATA_W'($past(cntFf)))
    else $error("clearing read lost old value");
  w1c_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    doWrite && hitReg(awAddrFf, rba_pkg::W1C_OFF) && w1cSet == '0
    |=> (w1cFf & $past(wBits)) == '0 && (w1cFf == ($past(w1cFf) & ~$past(wBits))))
    else $error("write-one-clear wrong");
  zero_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    doWrite && hitReg(awAddrFf, rba_pkg::ZCLR_OFF) && zeroClrSet == '0 && (&wStrbFf)
    |=> zeroClrFf == ($past(zeroClrFf) & $past(wDataFf)))
    else $error("write-zero-clear wrong");
  low_latch_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
    ##1 ((~$past(condLow)) & ~lowLatchFf) == '0)
    else $error("latch-low missed a drop");
  high_latch_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    ##1 ($past(condHigh) & ~highLatchFf) == '0)
    else $error("latch-high missed a rise");
  pulse_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    pulseFf != '0 && !(doWrite && hitReg(awAddrFf, rba_pkg::CMD_OFF)) |=> pulseFf == '0)
    else $error("self-clearing bit stuck");
  irq_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    ##1 (($past(irqEvt)) & ~irqStatFf) == '0)
    else $error("interrupt event lost");
  phy_start_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    miimStartFf |-> phyStateFf == rba_pkg::PHY_BUSY ##1 !miimStartFf)
    else $error("phy start not a single pulse");
endmodule : rba_register_bank

// ### verification/rba_miim_model.sv
`timescale 1ns/1ps
// PHY management engine stand-in: answers each start after a set lag
module rba_miim_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  lag,
  input  wire logic        miimStart,
  input  wire logic [4:0]  miimPhyAddr,
  input  wire logic [4:0]  miimRegAddr,
  output logic             miimDone,
  output logic [15:0]      miimRdData
);
  int waitCnt;

  // Data lines toggle outside the done cycle so stale data never looks valid
  always @(posedge clk) begin
    miimDone <= 1'b0;
    miimRdData <= ~miimRdData;
    if (!rst_n) begin
      waitCnt <= 0;
      miimRdData <= 16'h0000;
    end else if (miimStart) begin
      waitCnt <= lag + 1;
    end else if (waitCnt == 1) begin
      miimDone <= 1'b1;
      miimRdData <= {6'h2a, miimPhyAddr, miimRegAddr};
      waitCnt <= 0;
    end else if (waitCnt > 1) begin
      waitCnt <= waitCnt - 1;
    end
  end
endmodule : rba_miim_model

// ### verification/test_register_bit_access_types.sv
`timescale 1ns/1ps
module test_register_bit_access_types;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, countEvent, irq;
  logic        miimStart, miimRead, miimDone;
  logic [7:0]  awaddr, araddr, condLow, condHigh, lag;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] wdata, rdata, hwStatus, w1cSet, zeroClrSet, ctrlOut, keyOut, cmdPulse, rd;
  logic [31:0] pulseSeen = 32'h0000_0000;
  logic [4:0]  miimPhyAddr, miimRegAddr;
  logic [15:0] miimWrData, miimRdData;
  int          err_count, checks_done, n;
  int          pulseCycles = 0;

  rba_register_bank u_dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hwStatus(hwStatus), .countEvent(countEvent), .w1cSet(w1cSet), .zeroClrSet(zeroClrSet),
    .condLow(condLow), .condHigh(condHigh), .ctrlOut(ctrlOut), .keyOut(keyOut),
    .cmdPulse(cmdPulse), .irq(irq), .miimStart(miimStart), .miimRead(miimRead),
    .miimPhyAddr(miimPhyAddr), .miimRegAddr(miimRegAddr), .miimWrData(miimWrData),
    .miimDone(miimDone), .miimRdData(miimRdData)
  );

  rba_miim_model u_phy (
    .clk(clk), .rst_n(rst_n), .lag(lag), .miimStart(miimStart),
    .miimPhyAddr(miimPhyAddr), .miimRegAddr(miimRegAddr),
    .miimDone(miimDone), .miimRdData(miimRdData)
  );

  // Clock, 5 ns period
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts self-clearing pulse cycles seen at the ports
  always @(posedge clk) begin
    if (cmdPulse !== 32'h0000_0000) begin
      pulseCycles <= pulseCycles + 1;
      pulseSeen <= pulseSeen | cmdPulse;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Handshakes judged at the falling edge, where registered outputs are settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    bit ta, tw, tb;
    tb = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = awvalid && (awready === 1'b1);
      tw = wvalid && (wready === 1'b1);
      tb = (bvalid === 1'b1);
      rsp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    // One idle edge, so a following call never re-raises bready in this time step
    @(posedge clk);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    bit ta, tr;
    tr = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = arvalid && (arready === 1'b1);
      tr = (rvalid === 1'b1);
      rd = rdata;
      rsp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    // Idle edge keeps back-to-back reads from assigning rready twice at once
    @(posedge clk);
  endtask : axr

  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim;
  end

  // Main sequence
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, countEvent} = 7'h00;
    {awaddr, araddr, wstrb, wdata, hwStatus, w1cSet, zeroClrSet} = '0;
    condLow = 8'hff;
    condHigh = 8'h00;
    lag = 8'd12;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(rba_pkg::CTRL_OFF);
    chk("ctrl reset", rd, 32'h0000_0000);
    axw(rba_pkg::CTRL_OFF, 32'ha5a5_5a5a);
    axw(rba_pkg::CTRL_OFF, 32'h1111_1111, 4'h1);
    axr(rba_pkg::CTRL_OFF);
    chk("ctrl", rd, 32'ha5a5_5a11);
    chk("ctrlOut", ctrlOut, 32'ha5a5_5a11);
    hwStatus <= 32'h1234_abcd;
    axw(rba_pkg::STATUS_OFF, 32'hffff_ffff);
    chk("status wr resp", {30'h0, rsp}, {30'h0, rba_pkg::RESP_SLVERR});
    axr(rba_pkg::STATUS_OFF);
    chk("status", rd, 32'h1234_abcd);
    // Three back-to-back events
    countEvent <= 1'b1;
    repeat (3) @(posedge clk);
    countEvent <= 1'b0;
    axr(rba_pkg::EVTCNT_OFF);
    chk("evtcnt first", rd, 32'h0000_0003);
    axw(rba_pkg::EVTCNT_OFF, 32'h0000_0055);
    chk("evtcnt wr resp", {30'h0, rsp}, {30'h0, rba_pkg::RESP_SLVERR});
    axr(rba_pkg::EVTCNT_OFF);
    chk("evtcnt second", rd, 32'h0000_0000);
    axw(rba_pkg::KEY_OFF, 32'hcafe_0001);
    chk("keyOut", keyOut, 32'hcafe_0001);
    // Bit 0 set held during the clearing write: set must win
    w1cSet <= 32'h0000_00ff;
    @(posedge clk);
    w1cSet <= 32'h0000_0001;
    axw(rba_pkg::W1C_OFF, 32'h0000_000f);
    w1cSet <= 32'h0000_0000;
    axr(rba_pkg::W1C_OFF);
    chk("w1c", rd, 32'h0000_00f1);
    zeroClrSet <= 32'h0000_000f;
    @(posedge clk);
    zeroClrSet <= 32'h0000_0000;
    axw(rba_pkg::ZCLR_OFF, 32'hffff_fff3);
    axr(rba_pkg::ZCLR_OFF);
    chk("zero clear", rd, 32'h0000_0003);
    // One-cycle glitches on both latch inputs
    condLow <= 8'hfe;
    condHigh <= 8'h01;
    @(posedge clk);
    condLow <= 8'hff;
    condHigh <= 8'h00;
    @(posedge clk);
    axr(rba_pkg::LATCH_OFF);
    chk("latch held", rd, 32'h0000_01fe);
    axr(rba_pkg::LATCH_OFF);
    chk("latch released", rd, 32'h0000_00ff);
    axw(rba_pkg::CMD_OFF, 32'h0000_0005);
    axw(rba_pkg::CMD_OFF, 32'h0000_0000);
    axr(rba_pkg::CMD_OFF);
    chk("pulse read", rd, 32'h0000_0000);
    chk("pulse cycles", pulseCycles, 32'h0000_0001);
    chk("pulse bits", pulseSeen, 32'h0000_0005);
    axr(rba_pkg::IRQ_STAT_OFF);
    chk("irq stat", rd, 32'h0000_0007);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    axw(rba_pkg::IRQ_EN_OFF, 32'h0000_0004);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    axw(rba_pkg::IRQ_CLR_OFF, 32'h0000_000f);
    axr(rba_pkg::IRQ_STAT_OFF);
    chk("irq cleared", rd, 32'h0000_0000);
    chk("irq off", {31'h0, irq}, 32'h0000_0000);
    // Slow PHY read of phy 3 reg 2, then prompt write
    axw(rba_pkg::PHY_CMD_OFF, 32'h0462_0000);
    chk("phy rd fields", {21'h0, miimRead, miimPhyAddr, miimRegAddr}, 32'h0000_0462);
    n = 0;
    do begin
      axr(rba_pkg::PHY_DATA_OFF);
      n++;
    end while (rd[31] !== 1'b0 && n < 50);
    chk("phy rd data", rd, 32'h0000_a862);
    // Drop the first done flag so only the write command can raise it again
    axw(rba_pkg::IRQ_CLR_OFF, 32'h0000_0008);
    lag <= 8'd0;
    axw(rba_pkg::PHY_CMD_OFF, 32'h0065_5a5a);
    chk("phy wr fields", {21'h0, miimRead, miimPhyAddr, miimRegAddr}, 32'h0000_0065);
    chk("phy wr data", {16'h0, miimWrData}, 32'h0000_5a5a);
    repeat (4) @(posedge clk);
    axr(rba_pkg::IRQ_STAT_OFF);
    chk("phy done flag", rd, 32'h0000_0008);
    axr(8'h40);
    chk("unmapped rd", rd, 32'h0000_0000);
    chk("unmapped rd resp", {30'h0, rsp}, {30'h0, rba_pkg::RESP_SLVERR});
    axw(8'h40, 32'h0000_0000);
    chk("unmapped wr resp", {30'h0, rsp}, {30'h0, rba_pkg::RESP_SLVERR});
    end_sim;
  end
endmodule : test_register_bit_access_types
